// file: inc/pbms_map.svh
// Offsets, field positions, reset values and counts of the port-B data path
`ifndef PBMS_MAP_SVH
`define PBMS_MAP_SVH
// Data width and lane layout
`define PBMS_DW 36
`define PBMS_LANE_W 9
`define PBMS_LANES 4
// Register offsets (byte addresses)
`define PBMS_CTRL_OFS 12'h000
`define PBMS_STAT_OFS 12'h004
// Control field position and reset value
`define PBMS_CTRL_ODD_BIT 0
`define PBMS_CTRL_ODD_RST 1'h1
// Zero fill above the status fields
`define PBMS_STAT_PAD 21'h0
// AXI responses
`define PBMS_RESP_OKAY 2'h0
`define PBMS_RESP_SLVERR 2'h2
// Index of the last unit of a long word per bus size
`define PBMS_LAST_LONG 2'h0
`define PBMS_LAST_WORD 2'h1
`define PBMS_LAST_BYTE 2'h3
`endif

// file: inc/pbms_pkg.sv
// Types shared by the port-B data path
`include "pbms_map.svh"
package pbms_pkg;
  // One long word on the data bus
  typedef logic [`PBMS_DW-1:0] pbms_word_t;
  // Implemented port-B bus size, one-hot
  typedef enum logic [2:0] {
    SZ_LONG = 3'h1,
    SZ_WORD = 3'h2,
    SZ_BYTE = 3'h4
  } pbms_size_e;
  // Write strobe with the long word it carries
  typedef struct packed {
    logic strobe;
    pbms_word_t data;
  } pbms_wr_s;
endpackage

// file: rtl/pbms_parity_trees.sv
// Four nine-bit parity trees: lane check and parity regeneration
`timescale 1ns/1ns
`include "pbms_map.svh"
module pbms_parity_trees
  import pbms_pkg::*;
(
  // Lane data and polarity
  input logic [`PBMS_DW-1:0] data,
  input logic odd_sel,
  // Per-lane error and word with regenerated top bits
  output logic [`PBMS_LANES-1:0] err,
  output logic [`PBMS_DW-1:0] gen_data
);

  // One tree per lane; odd polarity wants an odd count of ones
  always_comb begin
    err = '0;
    gen_data = data;
    for (int i = 0; i < `PBMS_LANES; i++) begin
      err[i] = (^data[`PBMS_LANE_W*i +: `PBMS_LANE_W]) ^ odd_sel;
      gen_data[`PBMS_LANE_W*i+`PBMS_LANE_W-1] =
        (^data[`PBMS_LANE_W*i +: `PBMS_LANE_W-1]) ^ odd_sel;
    end
  end

endmodule

// file: rtl/pbms_portb_path.sv
// Port-B bus matching, byte swapping and two-port parity with an AXI4-Lite slave
`timescale 1ns/1ns
`include "pbms_map.svh"
////////////////////////////////////////////////////////////////////////////////
// What this block does
// - Second FIFO receives only whole long words; long size commits each write.
// - Narrow writes gather in holding registers; the final unit commits.
// - A write with a new bus size restarts gathering, dropping partial data.
// - Lanes unused by the narrow bus size are ignored on writes.
// - Both size selects high: read first mail, write second mail, long word.
// - Mail access leaves sizing state and stored size untouched.
// - Each edge uses the registered size and endian selects.
// - Four swap modes with every size; mail data never swapped.
// - Swapping moves whole bytes only, bit order kept.
// - Swap mode taken at a long word's first unit and held.
// - Narrow reads swap first, then present units in size order.
// - Narrow writes gather first, swap when the long word commits.
// - Port A checks all four bytes; error output low on any failure.
// - Port B error output counts only bytes the bus size uses.
// - Bytes are nine-bit lanes; port B valid lanes follow bus size.
// - Polarity select picks odd or even checking.
// - Port A mail read with generation holds port A error high.
// - Port B mail read with generation holds port B error high.
// - Generation replaces each byte's top bit with parity of lower eight.
// - Writes store all nine bits of every byte as applied.
// - FIFO parity generated at the edge that fetches a new long word.
// - Generating parity on a mail read leaves the mail register intact.
// - Size selects captured each edge without a mail select, endian select each edge; effective next edge.
////////////////////////////////////////////////////////////////////////////////
module pbms_portb_path
  import pbms_pkg::*;
(
  // Clock and reset
  input logic mclk,
  input logic resetn,
  // AXI4-Lite write channels
  input logic [11:0] s_axi_awaddr,
  input logic s_axi_awvalid,
  output logic s_axi_awready,
  input logic [31:0] s_axi_wdata,
  input logic [3:0] s_axi_wstrb,
  input logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input logic s_axi_bready,
  // AXI4-Lite read channels
  input logic [11:0] s_axi_araddr,
  input logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input logic s_axi_rready,
  // Port A pins
  input logic porta_chip_select_n,
  input logic porta_enable,
  input logic porta_write_not_read,
  input logic porta_mail_select,
  input logic porta_parity_gen_sel,
  input logic [`PBMS_DW-1:0] porta_din,
  output logic [`PBMS_DW-1:0] porta_dout,
  output logic porta_data_oe_n,
  output logic porta_parity_error_n,
  // Port B pins
  input logic portb_chip_select_n,
  input logic portb_enable,
  input logic portb_write_not_read,
  input logic size_select_lo,
  input logic size_select_hi,
  input logic big_endian_select,
  input logic swap_select_lo,
  input logic swap_select_hi,
  input logic portb_parity_gen_sel,
  input logic [`PBMS_DW-1:0] portb_din,
  output logic [`PBMS_DW-1:0] portb_dout,
  output logic portb_data_oe_n,
  output logic portb_parity_error_n,
  // First FIFO head word and fetch strobe
  input pbms_word_t fifo1_rd_data,
  input logic fifo1_empty,
  output logic fifo1_rd_strobe,
  // Second FIFO commit and port A output register
  input logic fifo2_full,
  output pbms_wr_s fifo2_wr,
  input pbms_word_t fifo2_out_data,
  // Mail registers
  input pbms_word_t mail1_data,
  output logic mail1_rd_strobe,
  input pbms_word_t mail2_data,
  output pbms_wr_s mail2_wr
);

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Size select pair to implemented bus size
  function automatic pbms_size_e dec_size(input logic lo, input logic hi);
    pbms_size_e s;
    s = SZ_LONG;
    if (!hi && lo) begin
      s = SZ_BYTE;
    end else if (hi && !lo) begin
      s = SZ_WORD;
    end
    return s;
  endfunction

  // Index of the unit that closes a long word
  function automatic logic [1:0] last_idx(input pbms_size_e sz);
    logic [1:0] r;
    r = `PBMS_LAST_LONG;
    unique case (sz)
      SZ_LONG: r = `PBMS_LAST_LONG;
      SZ_WORD: r = `PBMS_LAST_WORD;
      SZ_BYTE: r = `PBMS_LAST_BYTE;
    endcase
    return r;
  endfunction

  // Lanes of port B in use for a bus size
  function automatic logic [3:0] lane_mask(input pbms_size_e sz, input logic be);
    logic [3:0] m;
    m = 4'hf;
    unique case (sz)
      SZ_LONG: m = 4'hf;
      SZ_WORD: m = be ? 4'hc : 4'h3;
      SZ_BYTE: m = be ? 4'h8 : 4'h1;
    endcase
    return m;
  endfunction

  // Byte-order swap; bits inside each lane never move
  function automatic pbms_word_t swap36(input pbms_word_t w, input logic [1:0] mode);
    pbms_word_t r;
    r = w;
    unique case (mode)
      2'h0: r = w;
      2'h1: r = {w[8:0], w[17:9], w[26:18], w[35:27]};
      2'h2: r = {w[17:0], w[35:18]};
      2'h3: r = {w[26:18], w[35:27], w[8:0], w[17:9]};
    endcase
    return r;
  endfunction

  // Drop one bus unit into its slot of the gathered word
  function automatic pbms_word_t place_unit(input pbms_word_t acc, input pbms_word_t bus,
                                            input pbms_size_e sz, input logic be,
                                            input logic [1:0] idx);
    pbms_word_t r;
    logic [1:0] p;
    r = acc;
    p = be ? 2'h3 - idx : idx;
    unique case (sz)
      SZ_LONG: r = bus;
      SZ_WORD: begin
        if (be ^ idx[0]) begin
          r[35:18] = be ? bus[35:18] : bus[17:0];
        end else begin
          r[17:0] = be ? bus[35:18] : bus[17:0];
        end
      end
      SZ_BYTE: r[`PBMS_LANE_W*p +: `PBMS_LANE_W] = be ? bus[35:27] : bus[8:0];
    endcase
    return r;
  endfunction

  // Pick one unit of a long word onto its bus lanes; other lanes read zero
  function automatic pbms_word_t take_unit(input pbms_word_t w, input pbms_size_e sz,
                                           input logic be, input logic [1:0] idx);
    pbms_word_t r;
    logic [1:0] p;
    logic [17:0] u18;
    logic [8:0] u9;
    r = w;
    p = be ? 2'h3 - idx : idx;
    u18 = (be ^ idx[0]) ? w[35:18] : w[17:0];
    u9 = w[`PBMS_LANE_W*p +: `PBMS_LANE_W];
    unique case (sz)
      SZ_LONG: r = w;
      SZ_WORD: r = be ? {u18, 18'h0} : {18'h0, u18};
      SZ_BYTE: r = be ? {u9, 27'h0} : {27'h0, u9};
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Port decode

  logic a_sel, a_mail_rd, a_gen;
  logic b_sel, b_mail, b_mail_wr, b_mail_rd, b_gen, b_fifo_wr, b_fifo_rd;
  logic odd_sel_ff;

  // Chip select, enable and direction per port
  assign a_sel = !porta_chip_select_n && porta_enable;
  assign a_mail_rd = a_sel && !porta_write_not_read && porta_mail_select;
  assign a_gen = a_mail_rd && porta_parity_gen_sel;
  assign b_sel = !portb_chip_select_n && portb_enable;
  assign b_mail = size_select_lo && size_select_hi;
  assign b_mail_wr = b_sel && portb_write_not_read && b_mail;
  assign b_mail_rd = b_sel && !portb_write_not_read && b_mail;
  assign b_gen = b_mail_rd && portb_parity_gen_sel;
  assign b_fifo_wr = b_sel && portb_write_not_read && !b_mail && !fifo2_full;
  assign b_fifo_rd = b_sel && !portb_write_not_read && !b_mail;

  ////////////////////////////////////////////////////////////////////////////////
  // Size and endian capture

  logic size_select_lo_reg, size_select_hi_reg, big_endian_select_reg;
  pbms_size_e cur_size;

  // Captured each edge; a mail select keeps the previous size
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      size_select_lo_reg <= 1'h0;
      size_select_hi_reg <= 1'h0;
      big_endian_select_reg <= 1'h0;
    end else begin
      big_endian_select_reg <= big_endian_select;
      if (!b_mail) begin
        size_select_lo_reg <= size_select_lo;
        size_select_hi_reg <= size_select_hi;
      end
    end
  end

  assign cur_size = dec_size(size_select_lo_reg, size_select_hi_reg);

  ////////////////////////////////////////////////////////////////////////////////
  // Second FIFO write gathering

  pbms_size_e wr_size_ff;
  logic [1:0] wr_cnt_ff, wr_swap_ff, wr_idx, wr_swap;
  pbms_word_t wr_asm_ff, wr_asm;
  logic wr_last, wr_commit;
  pbms_wr_s fifo2_wr_ff, mail2_wr_ff;

  // Unit index, held swap mode and gathered word for this write
  always_comb begin
    wr_idx = (cur_size != wr_size_ff) ? 2'h0 : wr_cnt_ff;
    wr_swap = (wr_idx == 2'h0) ? {swap_select_hi, swap_select_lo} : wr_swap_ff;
    wr_asm = place_unit(wr_asm_ff, portb_din, cur_size, big_endian_select_reg, wr_idx);
    wr_last = (wr_idx == last_idx(cur_size));
    wr_commit = b_fifo_wr && wr_last;
  end

  // Holding registers advance on each accepted FIFO write
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      wr_size_ff <= SZ_LONG;
      wr_cnt_ff <= 2'h0;
      wr_swap_ff <= 2'h0;
      wr_asm_ff <= '0;
    end else if (b_fifo_wr) begin
      wr_size_ff <= cur_size;
      wr_swap_ff <= wr_swap;
      wr_asm_ff <= wr_asm;
      wr_cnt_ff <= wr_last ? 2'h0 : wr_idx + 2'h1;
    end
  end

  // Long-word commit and raw second-mail write
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      fifo2_wr_ff <= '0;
      mail2_wr_ff <= '0;
    end else begin
      fifo2_wr_ff.strobe <= wr_commit;
      if (wr_commit) begin
        fifo2_wr_ff.data <= swap36(wr_asm, wr_swap);
      end
      mail2_wr_ff.strobe <= b_mail_wr;
      if (b_mail_wr) begin
        mail2_wr_ff.data <= portb_din;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // First FIFO read splitting and port B output

  pbms_size_e rd_size_ff;
  logic [1:0] rd_cnt_ff, rd_idx;
  pbms_word_t rd_buf_ff, rd_word, f1_swapped, f1_gen, b_tree_in, b_tree_gen;
  logic rd_fetch, rd_go, fifo1_rd_strobe_ff, mail1_rd_strobe_ff;
  logic [3:0] b_err;
  pbms_word_t portb_dout_ff;
  logic portb_data_oe_n_ff, portb_parity_error_n_ff;

  // A new long word is fetched at a size change or after the last unit
  assign rd_fetch = (cur_size != rd_size_ff) || (rd_cnt_ff == 2'h0);
  assign rd_go = b_fifo_rd && !(rd_fetch && fifo1_empty);
  assign rd_idx = (cur_size != rd_size_ff) ? 2'h0 : rd_cnt_ff;
  assign f1_swapped = swap36(fifo1_rd_data, {swap_select_hi, swap_select_lo});
  assign rd_word = !rd_fetch ? rd_buf_ff :
                   portb_parity_gen_sel ? f1_gen : f1_swapped;
  assign b_tree_in = b_gen ? mail1_data : portb_din;

  // Regeneration on the fetched word
  pbms_parity_trees u_fetch_trees (
    .data(f1_swapped),
    .odd_sel(odd_sel_ff),
    .err(),
    .gen_data(f1_gen)
  );

  // Port B trees shared between bus check and first-mail generation
  pbms_parity_trees u_portb_trees (
    .data(b_tree_in),
    .odd_sel(odd_sel_ff),
    .err(b_err),
    .gen_data(b_tree_gen)
  );

  // Read-side unit counter and held long word
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      rd_size_ff <= SZ_LONG;
      rd_cnt_ff <= 2'h0;
      rd_buf_ff <= '0;
    end else if (rd_go) begin
      rd_size_ff <= cur_size;
      rd_buf_ff <= rd_word;
      rd_cnt_ff <= (rd_idx == last_idx(cur_size)) ? 2'h0 : rd_idx + 2'h1;
    end
  end

  // Port B output register, enable, strobes and error flag
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      portb_dout_ff <= '0;
      portb_data_oe_n_ff <= 1'h1;
      portb_parity_error_n_ff <= 1'h1;
      fifo1_rd_strobe_ff <= 1'h0;
      mail1_rd_strobe_ff <= 1'h0;
    end else begin
      portb_data_oe_n_ff <= portb_chip_select_n || portb_write_not_read;
      fifo1_rd_strobe_ff <= rd_go && rd_fetch;
      mail1_rd_strobe_ff <= b_mail_rd;
      if (b_mail_rd) begin
        portb_dout_ff <= portb_parity_gen_sel ? b_tree_gen : mail1_data;
      end else if (rd_go) begin
        portb_dout_ff <= take_unit(rd_word, cur_size, big_endian_select_reg, rd_idx);
      end
      portb_parity_error_n_ff <= b_gen ||
        !(|(b_err & lane_mask(cur_size, big_endian_select_reg)));
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Port A check and second-mail read

  logic [3:0] a_err;
  pbms_word_t a_tree_in, a_tree_gen, porta_dout_ff;
  logic porta_data_oe_n_ff, porta_parity_error_n_ff;

  assign a_tree_in = a_gen ? mail2_data : porta_din;

  // Port A trees shared between bus check and second-mail generation
  pbms_parity_trees u_porta_trees (
    .data(a_tree_in),
    .odd_sel(odd_sel_ff),
    .err(a_err),
    .gen_data(a_tree_gen)
  );

  // Port A output register and error flag
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      porta_dout_ff <= '0;
      porta_data_oe_n_ff <= 1'h1;
      porta_parity_error_n_ff <= 1'h1;
    end else begin
      porta_data_oe_n_ff <= porta_chip_select_n || porta_write_not_read;
      if (!porta_chip_select_n && !porta_write_not_read) begin
        porta_dout_ff <= !porta_mail_select ? fifo2_out_data :
                         a_gen ? a_tree_gen : mail2_data;
      end
      porta_parity_error_n_ff <= a_gen || !(|a_err);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave: control and status

  logic aw_held_ff, w_held_ff, wr_go, aw_hs, w_hs, ar_hs;
  logic [11:0] aw_addr_ff;
  logic [31:0] w_data_ff, status;
  logic [3:0] w_strb_ff;
  logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff;

  // Word-aligned decode: bit 0 control, bit 1 status
  function automatic logic [1:0] dec_reg(input logic [11:0] a);
    logic [11:0] w;
    w = {a[11:2], 2'h0};
    return {w == `PBMS_STAT_OFS, w == `PBMS_CTRL_OFS};
  endfunction

  // Decoded held write address and offered read address
  logic [1:0] aw_dec, ar_dec;
  assign aw_dec = dec_reg(aw_addr_ff);
  assign ar_dec = dec_reg(s_axi_araddr);

  assign aw_hs = s_axi_awvalid && awready_ff;
  assign w_hs = s_axi_wvalid && wready_ff;
  assign ar_hs = s_axi_arvalid && arready_ff;
  assign wr_go = aw_held_ff && w_held_ff && !bvalid_ff;
  assign status = {`PBMS_STAT_PAD, wr_swap_ff, big_endian_select_reg, size_select_hi_reg,
                   size_select_lo_reg, rd_cnt_ff, wr_cnt_ff, portb_parity_error_n_ff,
                   porta_parity_error_n_ff};

  // Address and data taken in either order, held until the write is done
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      aw_held_ff <= 1'h0;
      w_held_ff <= 1'h0;
      awready_ff <= 1'h0;
      wready_ff <= 1'h0;
      aw_addr_ff <= 12'h000;
      w_data_ff <= 32'h0000_0000;
      w_strb_ff <= 4'h0;
    end else begin
      aw_held_ff <= aw_hs || (aw_held_ff && !wr_go);
      w_held_ff <= w_hs || (w_held_ff && !wr_go);
      awready_ff <= !(aw_hs || (aw_held_ff && !wr_go));
      wready_ff <= !(w_hs || (w_held_ff && !wr_go));
      if (aw_hs) begin
        aw_addr_ff <= s_axi_awaddr;
      end
      if (w_hs) begin
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end
    end
  end

  // Write response and control register; status ignores writes
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      bvalid_ff <= 1'h0;
      bresp_ff <= `PBMS_RESP_OKAY;
      odd_sel_ff <= `PBMS_CTRL_ODD_RST;
    end else begin
      if (wr_go) begin
        bvalid_ff <= 1'h1;
        bresp_ff <= (|aw_dec) ? `PBMS_RESP_OKAY : `PBMS_RESP_SLVERR;
        if (aw_dec[0] && w_strb_ff[0]) begin
          odd_sel_ff <= w_data_ff[`PBMS_CTRL_ODD_BIT];
        end
      end else if (s_axi_bready) begin
        bvalid_ff <= 1'h0;
      end
    end
  end

  // Read channel: one outstanding read, answered the cycle after the address
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      arready_ff <= 1'h0;
      rvalid_ff <= 1'h0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= `PBMS_RESP_OKAY;
    end else begin
      arready_ff <= !(ar_hs || (rvalid_ff && !s_axi_rready));
      if (ar_hs) begin
        rvalid_ff <= 1'h1;
        rdata_ff <= ar_dec[0] ? {31'h0, odd_sel_ff} :
                    ar_dec[1] ? status : 32'h0000_0000;
        rresp_ff <= (|ar_dec) ? `PBMS_RESP_OKAY : `PBMS_RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_ff <= 1'h0;
      end
    end
  end

  // Outputs straight from their flip-flops
  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign porta_dout = porta_dout_ff;
  assign porta_data_oe_n = porta_data_oe_n_ff;
  assign porta_parity_error_n = porta_parity_error_n_ff;
  assign portb_dout = portb_dout_ff;
  assign portb_data_oe_n = portb_data_oe_n_ff;
  assign portb_parity_error_n = portb_parity_error_n_ff;
  assign fifo1_rd_strobe = fifo1_rd_strobe_ff;
  assign mail1_rd_strobe = mail1_rd_strobe_ff;
  assign fifo2_wr = fifo2_wr_ff;
  assign mail2_wr = mail2_wr_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  // Final unit of a long word on the write side
  sequence s_last_unit;
    b_fifo_wr && wr_last;
  endsequence

  // Narrow write that starts over after a size change
  sequence s_restart;
    b_fifo_wr && (cur_size != wr_size_ff) && (cur_size != SZ_LONG);
  endsequence

  a_long_immediate: assert property (
    b_fifo_wr && cur_size == SZ_LONG |=> fifo2_wr_ff.strobe &&
      fifo2_wr_ff.data == swap36($past(portb_din), $past(wr_swap)))
    else $error("long-word write not committed at once");
  a_commit_cause: assert property (
    fifo2_wr_ff.strobe |-> $past(wr_commit))
    else $error("commit without a final unit");
  a_size_restart: assert property (
    s_restart |=> wr_cnt_ff == 2'h1 && !fifo2_wr_ff.strobe)
    else $error("size change did not restart gathering");
  a_mail_undisturbed: assert property (
    b_mail_wr || b_mail_rd |=> $stable(wr_cnt_ff) && $stable(rd_cnt_ff) &&
      $stable(size_select_lo_reg) && $stable(size_select_hi_reg))
    else $error("mail access disturbed sizing");
  a_mail2_raw: assert property (
    b_mail_wr |=> mail2_wr_ff.strobe && mail2_wr_ff.data == $past(portb_din))
    else $error("second mail write not raw long word");
  a_swap_held: assert property (
    s_last_unit ##0 (wr_idx != 2'h0) |=>
      fifo2_wr_ff.data == swap36($past(wr_asm), $past(wr_swap_ff)))
    else $error("swap mode not held over the long word");
  a_porta_parity_error_n_gen_hold: assert property (
    a_gen |=> porta_parity_error_n_ff)
    else $error("port A error not held during generation");
  a_portb_parity_error_n_gen_hold: assert property (
    b_gen |=> portb_parity_error_n_ff)
    else $error("port B error not held during generation");
  a_portb_parity_error_n_byte_lane: assert property (
    !b_gen && cur_size == SZ_BYTE && big_endian_select_reg |=>
      portb_parity_error_n_ff == (($past(b_err) & 4'h8) == 4'h0))
    else $error("port B error uses wrong lanes");
  a_size_capture: assert property (
    !b_mail |=> size_select_lo_reg == $past(size_select_lo) &&
      size_select_hi_reg == $past(size_select_hi))
    else $error("size selects not captured");

endmodule

// file: verification/pbms_partner.sv
// Far-side model: FIFO1 head, FIFO2 output register and both mail registers
`timescale 1ns/1ns
module pbms_partner import pbms_pkg::*; (
  // Clock, reset and strobes from the data path
  input logic mclk, resetn, fifo1_rd_strobe,
  input pbms_wr_s fifo2_wr, mail2_wr,
  // Stored words and status toward the data path
  output pbms_word_t fifo1_rd_data, fifo2_out_data, mail1_data, mail2_data,
  output logic fifo1_empty, fifo2_full
);
  // Mail1 holds a fixed word; neither FIFO ever blocks
  assign mail1_data = 36'h1_2345_6789;
  assign fifo1_empty = 1'h0;
  assign fifo2_full = 1'h0;
  // Head word steps only on a fetch; stores keep all nine bits of each byte
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      fifo1_rd_data <= {9'h101, 9'h0F2, 9'h033, 9'h1C4};
      mail2_data <= '0;
      fifo2_out_data <= '0;
    end else begin
      if (fifo1_rd_strobe) fifo1_rd_data <= ~fifo1_rd_data;
      if (mail2_wr.strobe) mail2_data <= mail2_wr.data;
      if (fifo2_wr.strobe) fifo2_out_data <= fifo2_wr.data;
    end
  end
endmodule

// file: verification/test_portb_bus_match_swap_parity.sv
// Self-checking bench for the port-B data path
`timescale 1ns/1ns
`include "pbms_map.svh"
module test_portb_bus_match_swap_parity import pbms_pkg::*; ;
  localparam logic [8:0] ba = 9'h101, bb = 9'h0F2, bc = 9'h033, bd = 9'h1C4;
  localparam logic [26:0] jk = 27'h2AA_AAAA;
  localparam pbms_word_t mw = 36'h9_8765_4321;
  logic mclk = 0, resetn = 0;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, porta_chip_select_n = 1, porta_enable = 0, porta_write_not_read = 0;
  logic porta_mail_select = 0, porta_parity_gen_sel = 0, portb_chip_select_n = 1;
  logic portb_enable = 0, portb_write_not_read = 0, size_select_lo = 0, size_select_hi = 0;
  logic big_endian_select = 0, swap_select_lo = 0, swap_select_hi = 0;
  logic portb_parity_gen_sel = 0, porta_data_oe_n, porta_parity_error_n;
  logic portb_data_oe_n, portb_parity_error_n, fifo1_empty, fifo1_rd_strobe;
  logic fifo2_full, mail1_rd_strobe, rd = 0;
  logic [35:0] porta_din = '0, portb_din = '0, porta_dout, portb_dout;
  pbms_word_t fifo1_rd_data, fifo2_out_data, mail1_data, mail2_data;
  pbms_wr_s fifo2_wr, mail2_wr;
  int failures = 0, compares = 0, cyc = 0;
  pbms_portb_path i_dut (.*);
  pbms_partner i_partner (.*);
  //////////////////////////////////////////////////////////////////////////////
  // Clock and run limit
  initial forever #5 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 2000) begin
      failures++;
      end_sim();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  task end_sim;
    $display("failures %0d compares %0d", failures, compares);
    if (failures == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input string n, input logic [35:0] e, input logic [35:0] s);
    compares++;
    if (s !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  // Bus cycles: readies sampled half a cycle before the edge that takes them
  task axw(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    logic aw, w, b;
    logic [1:0] br;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(negedge mclk);
      aw = s_axi_awready;
      w = s_axi_wready;
      b = s_axi_bvalid;
      br = s_axi_bresp;
      @(posedge mclk);
      if (aw) s_axi_awvalid <= 0;
      if (w) s_axi_wvalid <= 0;
    end while (!b);
    s_axi_bready <= 0;
    chk("bresp", r, br);
  endtask
  task axr(input logic [11:0] a, input logic [31:0] e, input logic [1:0] r);
    logic ar, v;
    logic [31:0] d;
    logic [1:0] rr;
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(negedge mclk);
      ar = s_axi_arready;
      v = s_axi_rvalid;
      d = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge mclk);
      if (ar) s_axi_arvalid <= 0;
    end while (!v);
    s_axi_rready <= 0;
    chk("rdata", e, d);
    chk("rresp", r, rr);
  endtask
  // One port-B cycle: en low gives an idle cycle that still sets the selects
  task pbw(input logic en, input logic [1:0] s, input logic be, input logic [1:0] sw,
           input logic [35:0] d);
    @(posedge mclk);
    portb_chip_select_n <= !en;
    portb_enable <= en;
    portb_write_not_read <= !rd;
    {size_select_hi, size_select_lo} <= s;
    big_endian_select <= be;
    {swap_select_hi, swap_select_lo} <= sw;
    portb_din <= d;
  endtask
  task wcommit(input pbms_word_t e);
    do @(negedge mclk); while (fifo2_wr.strobe !== 1'h1);
    chk("fifo2_wr", e, fifo2_wr.data);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (8) @(posedge mclk);
    resetn <= 1;
    repeat (2) @(posedge mclk);
    axr(`PBMS_CTRL_OFS, 32'h0000_0001, `PBMS_RESP_OKAY);
    axr(12'h008, '0, `PBMS_RESP_SLVERR);
    axw(12'h00C, '0, `PBMS_RESP_SLVERR);
    pbw(0, 2'h0, 0, 2'h2, '0);
    pbw(1, 2'h0, 0, 2'h2, {ba, bb, bc, bd});
    wcommit({bc, bd, ba, bb});
    pbw(0, 2'h2, 0, 2'h0, '0);
    pbw(1, 2'h2, 0, 2'h0, {18'h0_0000, bc, bd});
    pbw(0, 2'h1, 1, 2'h1, '0);
    pbw(1, 2'h1, 1, 2'h1, {ba, jk});
    pbw(1, 2'h1, 1, 2'h1, {bb, jk});
    pbw(1, 2'h3, 1, 2'h1, mw);
    pbw(1, 2'h1, 1, 2'h2, {bc, jk});
    pbw(1, 2'h1, 1, 2'h2, {bd, jk});
    pbw(0, 2'h1, 1, 2'h0, {9'h001, 27'h000_0000});
    wcommit({bd, bc, bb, ba});
    chk("mail2", mw, mail2_data);
    @(posedge mclk);
    porta_din <= '0;
    repeat (2) @(negedge mclk);
    chk("porta_err", 0, porta_parity_error_n);
    chk("portb_err", 1, portb_parity_error_n);
    axw(`PBMS_CTRL_OFS, '0, `PBMS_RESP_OKAY);
    axr(`PBMS_CTRL_OFS, '0, `PBMS_RESP_OKAY);
    repeat (2) @(negedge mclk);
    chk("porta_err", 1, porta_parity_error_n);
    chk("portb_err", 0, portb_parity_error_n);
    rd = 1;
    pbw(0, 2'h2, 0, 2'h2, '0);
    pbw(1, 2'h2, 0, 2'h2, '0);
    pbw(1, 2'h2, 0, 2'h0, '0);
    @(negedge mclk);
    chk("portb_dout", {18'h0, ba, bb}, portb_dout);
    chk("fifo1_rd_strobe", 1, fifo1_rd_strobe);
    pbw(0, 2'h2, 0, 2'h0, '0);
    @(negedge mclk);
    chk("portb_dout", {18'h0, bc, bd}, portb_dout);
    pbw(1, 2'h3, 0, 2'h0, 36'h0_0000_0001);
    portb_parity_gen_sel <= 1;
    porta_chip_select_n <= 0;
    porta_mail_select <= 1;
    repeat (2) @(negedge mclk);
    chk("portb_dout", {9'h024, 9'h0D1, 9'h1B3, 9'h189}, portb_dout);
    chk("portb_err", 1, portb_parity_error_n);
    chk("mail1_rd_strobe", 1, mail1_rd_strobe);
    chk("porta_dout", mw, porta_dout);
    end_sim();
  end
endmodule
